// ### inc/oac_pkg.sv
// package: register map, field positions and encodings for the fuse access config block
package oac_pkg;
  // ==========================================================
  // register indices; the byte address on the bus is index*4
  localparam logic [7:0] OAC_IDX_PROG_CLOCK_CONFIG   = 8'h3E;
  localparam logic [7:0] OAC_IDX_FUSE_ACCESS_CONTROL = 8'h3F;
  localparam logic [7:0] OAC_IDX_EVAL_GATE           = 8'h3D;
  localparam logic [7:0] OAC_IDX_LOW_A_FIRST         = 8'h10;
  localparam logic [7:0] OAC_IDX_LOW_B_FIRST         = 8'h30;
  localparam int         OAC_TEST_COUNT              = 8;
  localparam int         OAC_HALF_COUNT              = 4;
  localparam int         OAC_ADDR_W                  = 10;
  // ==========================================================
  // reset values
  localparam logic [7:0] OAC_RST_PROG_CLOCK          = 8'h00;
  localparam logic [7:0] OAC_RST_FUSE_ACCESS         = 8'h00;
  localparam logic [7:0] OAC_RST_TEST                = 8'h00;
  localparam logic [7:0] OAC_ZERO_BYTE               = 8'h00;
  // bus response codes
  localparam logic [1:0] OAC_RSP_OKAY                = 2'h0;
  localparam logic [1:0] OAC_RSP_DECODE              = 2'h3;
  // ==========================================================
  // field positions
  localparam int         OAC_BIT_EXT_CLK             = 3;
  localparam int         OAC_BIT_BANK_SEL            = 5;
  localparam int         OAC_BIT_NEG_SW              = 4;
  localparam int         OAC_BIT_UPPER_WIN           = 3;
  localparam int         OAC_BIT_LOWER_WIN           = 2;
  localparam int         OAC_BIT_EVAL_GATE           = 0;
  localparam int         OAC_OP_LSB                  = 0;
  localparam int         OAC_OP_MSB                  = 1;
  // writable masks of the config registers
  localparam logic [7:0] OAC_MASK_PROG_CLOCK         = 8'h08;
  localparam logic [7:0] OAC_MASK_FUSE_ACCESS        = 8'h3F;
  localparam logic [7:0] OAC_MASK_EVAL_GATE          = 8'h01;
  // ==========================================================
  // fuse-array operations
  typedef enum logic [1:0] {
    OAC_OP_READ  = 2'h0,
    OAC_OP_LOAD  = 2'h1,
    OAC_OP_WRITE = 2'h2,
    OAC_OP_BURN  = 2'h3
  } oac_op_e;
  // bus answer state
  typedef enum logic {OAC_ST_IDLE, OAC_ST_DONE} oac_bus_state_e;
endpackage : oac_pkg

// ### rtl/oac_test_reg.sv
// module: one gated test register byte
`timescale 1ns/1ps
module oac_test_reg
  import oac_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst,       // async reset, high
  input  wire logic         wr_en,     // write strobe for this byte
  input  wire logic         enabled,   // bank and window open
  input  wire logic [W-1:0] wdata,     // write data
  output logic      [W-1:0] rdata      // gated read data
);
  logic [W-1:0] val_r;
  logic [W-1:0] val_nxt;

  // closed window: writes dropped
  always_comb begin
    val_nxt = val_r;
    if (wr_en && enabled) begin
      val_nxt = wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_r <= W'(OAC_RST_TEST);
    end else begin
      val_r <= val_nxt;
    end
  end

  // closed window: reads zero
  assign rdata = enabled ? val_r : '0;
endmodule : oac_test_reg

// ### rtl/oac_top.sv
// module: fuse-array access configuration registers on an Avalon-MM slave
// ==========================================================
// Overview of operation
// - ext_prog_clock_sel=1 picks external programming clock, 0 picks internal.
// - fuse registers reachable only after evaluation_access_gate is set to one.
// - test_bank_select 0 opens 0x30-0x37, 1 opens 0x10-0x17.
// - neg_rail_buffer_switch=1 closes line-input to negative rail switch.
// - upper_test_window_enable opens 34h-37h and 14h-17h.
// - lower_test_window_enable opens 30h-33h and 10h-13h.
// - fuse_op_select bits 1:0 choose read, load, write, burn; default read.
`timescale 1ns/1ps
module oac_top
  import oac_pkg::*;
(
  input  wire logic                  REF_CLK,          // 100 MHz clock
  input  wire logic                  SYS_RST,          // async reset, high
  input  wire logic [OAC_ADDR_W-1:0] AVS_ADDRESS,      // byte address
  input  wire logic                  AVS_READ,         // read request
  input  wire logic                  AVS_WRITE,        // write request
  input  wire logic [31:0]           AVS_WRITEDATA,    // write data
  input  wire logic [3:0]            AVS_BYTEENABLE,   // byte lanes
  output logic      [31:0]           AVS_READDATA,     // read data
  output logic                       AVS_WAITREQUEST,  // stall
  output logic [1:0]                 AVS_RESPONSE,     // 00 ok, 11 unmapped
  output logic                       EXT_PROG_CLOCK_SEL,     // external prog clock in use
  output logic                       NEG_RAIL_BUFFER_SWITCH, // switch closed
  output logic [1:0]                 FUSE_OP_SELECT,         // fuse operation
  output logic [OAC_TEST_COUNT-1:0]  LOW_BANK_OPEN,          // 0x10.. enables
  output logic [OAC_TEST_COUNT-1:0]  HIGH_BANK_OPEN          // 0x30.. enables
);
  // ==========================================================
  // state
  oac_bus_state_e st_r, st_nxt;
  logic [7:0]  clk_cfg_r, clk_cfg_nxt;
  logic [7:0]  fuse_cfg_r, fuse_cfg_nxt;
  logic [7:0]  gate_r, gate_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  rsp_r, rsp_nxt;
  logic        wait_r, wait_nxt;
  logic        commit;
  logic        win;
  logic [7:0]  idx;
  logic        lane0;
  logic        gate_on;
  logic [OAC_TEST_COUNT-1:0] low_en, high_en, low_wr, high_wr;
  logic [7:0]  low_rd  [OAC_TEST_COUNT];
  logic [7:0]  high_rd [OAC_TEST_COUNT];

  assign idx     = AVS_ADDRESS[OAC_ADDR_W-1:2];
  assign lane0   = AVS_BYTEENABLE[0];
  assign gate_on = gate_r[OAC_BIT_EVAL_GATE];
  // writes land only at the edge where the master sees waitrequest low
  assign commit  = (st_r == OAC_ST_DONE) && AVS_WRITE && lane0;

  // ==========================================================
  // window enables; windows split the eight bytes in two halves
  always_comb begin
    win     = 1'b0;
    low_en  = '0;
    high_en = '0;
    for (int i = 0; i < OAC_TEST_COUNT; i++) begin
      win = (i < OAC_HALF_COUNT) ? fuse_cfg_r[OAC_BIT_LOWER_WIN]
                                 : fuse_cfg_r[OAC_BIT_UPPER_WIN];
      low_en[i]  = gate_on && win && fuse_cfg_r[OAC_BIT_BANK_SEL];
      high_en[i] = gate_on && win && !fuse_cfg_r[OAC_BIT_BANK_SEL];
    end
  end

  // ==========================================================
  // test register bytes
  for (genvar g = 0; g < OAC_TEST_COUNT; g++) begin : g_test
    assign low_wr[g]  = commit && (idx == OAC_IDX_LOW_A_FIRST + 8'(g));
    assign high_wr[g] = commit && (idx == OAC_IDX_LOW_B_FIRST + 8'(g));
    oac_test_reg #(.W(8)) u_low (
      .clk(REF_CLK), .rst(SYS_RST), .wr_en(low_wr[g]), .enabled(low_en[g]),
      .wdata(AVS_WRITEDATA[7:0]), .rdata(low_rd[g]));
    oac_test_reg #(.W(8)) u_high (
      .clk(REF_CLK), .rst(SYS_RST), .wr_en(high_wr[g]), .enabled(high_en[g]),
      .wdata(AVS_WRITEDATA[7:0]), .rdata(high_rd[g]));
  end

  // ==========================================================
  // bus decode: take the request in idle, answer one cycle later with waitrequest low;
  // reads are captured at the take edge, writes land at the answer edge only
  always_comb begin
    st_nxt       = st_r;
    wait_nxt     = 1'b1;
    clk_cfg_nxt  = clk_cfg_r;
    fuse_cfg_nxt = fuse_cfg_r;
    gate_nxt     = gate_r;
    rd_nxt       = rd_r;
    rsp_nxt      = rsp_r;
    if (st_r == OAC_ST_DONE) begin
      st_nxt = OAC_ST_IDLE;
      if (commit) begin
        if (idx == OAC_IDX_EVAL_GATE) begin
          gate_nxt = AVS_WRITEDATA[7:0] & OAC_MASK_EVAL_GATE;
        end else if (idx == OAC_IDX_PROG_CLOCK_CONFIG) begin
          // gate closed: the write is dropped
          if (gate_on) clk_cfg_nxt = AVS_WRITEDATA[7:0] & OAC_MASK_PROG_CLOCK;
        end else if (idx == OAC_IDX_FUSE_ACCESS_CONTROL) begin
          if (gate_on) fuse_cfg_nxt = AVS_WRITEDATA[7:0] & OAC_MASK_FUSE_ACCESS;
        end
      end
    end else if (AVS_READ || AVS_WRITE) begin
      st_nxt   = OAC_ST_DONE;
      wait_nxt = 1'b0;
      rd_nxt   = '0;
      rsp_nxt  = OAC_RSP_OKAY;
      if (idx == OAC_IDX_EVAL_GATE) begin
        rd_nxt[7:0] = gate_r;
      end else if (idx == OAC_IDX_PROG_CLOCK_CONFIG) begin
        // gate closed: fuse registers read zero
        rd_nxt[7:0] = gate_on ? clk_cfg_r : OAC_ZERO_BYTE;
      end else if (idx == OAC_IDX_FUSE_ACCESS_CONTROL) begin
        rd_nxt[7:0] = gate_on ? fuse_cfg_r : OAC_ZERO_BYTE;
      end else if (idx >= OAC_IDX_LOW_A_FIRST && idx < OAC_IDX_LOW_A_FIRST + 8'(OAC_TEST_COUNT)) begin
        rd_nxt[7:0] = low_rd[idx[2:0]];
      end else if (idx >= OAC_IDX_LOW_B_FIRST && idx < OAC_IDX_LOW_B_FIRST + 8'(OAC_TEST_COUNT)) begin
        rd_nxt[7:0] = high_rd[idx[2:0]];
      end else begin
        rsp_nxt = OAC_RSP_DECODE;  // unmapped: decode error, data zero
      end
    end
  end

  // ==========================================================
  // bus and configuration state registers
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r       <= OAC_ST_IDLE;
      clk_cfg_r  <= OAC_RST_PROG_CLOCK;
      fuse_cfg_r <= OAC_RST_FUSE_ACCESS;
      gate_r     <= OAC_ZERO_BYTE;
      rd_r       <= '0;
      rsp_r      <= OAC_RSP_OKAY;
      wait_r     <= 1'b1;  // stall while in reset
    end else begin
      st_r       <= st_nxt;
      clk_cfg_r  <= clk_cfg_nxt;
      fuse_cfg_r <= fuse_cfg_nxt;
      gate_r     <= gate_nxt;
      rd_r       <= rd_nxt;
      rsp_r      <= rsp_nxt;
      wait_r     <= wait_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXT_PROG_CLOCK_SEL     <= 1'b0;
      NEG_RAIL_BUFFER_SWITCH <= 1'b0;
      FUSE_OP_SELECT         <= OAC_OP_READ;
      LOW_BANK_OPEN          <= '0;
      HIGH_BANK_OPEN         <= '0;
    end else begin
      EXT_PROG_CLOCK_SEL     <= clk_cfg_r[OAC_BIT_EXT_CLK];
      NEG_RAIL_BUFFER_SWITCH <= fuse_cfg_r[OAC_BIT_NEG_SW];
      FUSE_OP_SELECT         <= fuse_cfg_r[OAC_OP_MSB:OAC_OP_LSB];
      LOW_BANK_OPEN          <= low_en;
      HIGH_BANK_OPEN         <= high_en;
    end
  end

  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA    = rd_r;
  assign AVS_RESPONSE    = rsp_r;

  // ==========================================================
  // assertions
  property p_ext_clk;
    @(posedge REF_CLK) disable iff (SYS_RST) EXT_PROG_CLOCK_SEL == $past(clk_cfg_r[OAC_BIT_EXT_CLK]);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("clock select mismatch");
  property p_gate;
    @(posedge REF_CLK) disable iff (SYS_RST) !gate_on |=> $stable(fuse_cfg_r) && $stable(clk_cfg_r);
  endproperty
  a_gate: assert property (p_gate) else $error("fuse config changed while gate closed");
  property p_bank;
    @(posedge REF_CLK) disable iff (SYS_RST) (low_en & high_en) == '0;
  endproperty
  a_bank: assert property (p_bank) else $error("both banks open");
  property p_sw;
    @(posedge REF_CLK) disable iff (SYS_RST) NEG_RAIL_BUFFER_SWITCH == $past(fuse_cfg_r[OAC_BIT_NEG_SW]);
  endproperty
  a_sw: assert property (p_sw) else $error("switch mismatch");
  property p_upper;
    @(posedge REF_CLK) disable iff (SYS_RST) !fuse_cfg_r[OAC_BIT_UPPER_WIN] |-> (low_en[7:4] | high_en[7:4]) == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper window open");
  property p_lower;
    @(posedge REF_CLK) disable iff (SYS_RST) !fuse_cfg_r[OAC_BIT_LOWER_WIN] |-> (low_en[3:0] | high_en[3:0]) == '0;
  endproperty
  a_lower: assert property (p_lower) else $error("lower window open");
  property p_op;
    @(posedge REF_CLK) disable iff (SYS_RST) FUSE_OP_SELECT == $past(fuse_cfg_r[OAC_OP_MSB:OAC_OP_LSB]);
  endproperty
  a_op: assert property (p_op) else $error("operation mismatch");
  property p_wait;
    @(posedge REF_CLK) disable iff (SYS_RST) (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("answer late");
  property p_wait_one;
    @(posedge REF_CLK) disable iff (SYS_RST) !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");
  property p_rd_gate;
    @(posedge REF_CLK) disable iff (SYS_RST) AVS_READ && AVS_WAITREQUEST && !gate_on &&
      (idx == OAC_IDX_FUSE_ACCESS_CONTROL || idx == OAC_IDX_PROG_CLOCK_CONFIG) |=> AVS_READDATA == '0;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("fuse register visible with gate closed");
  property p_closed_rd;
    @(posedge REF_CLK) disable iff (SYS_RST) AVS_READ && AVS_WAITREQUEST && idx >= OAC_IDX_LOW_A_FIRST &&
      idx < OAC_IDX_LOW_A_FIRST + 8'(OAC_TEST_COUNT) && !low_en[idx[2:0]] |=> AVS_READDATA == '0;
  endproperty
  a_closed_rd: assert property (p_closed_rd) else $error("closed test register read nonzero");
  c_gate_on: cover property (@(posedge REF_CLK) disable iff (SYS_RST) $rose(gate_on));
  c_burn:    cover property (@(posedge REF_CLK) disable iff (SYS_RST) FUSE_OP_SELECT == OAC_OP_BURN);
  c_low:     cover property (@(posedge REF_CLK) disable iff (SYS_RST) LOW_BANK_OPEN != '0);
  c_high:    cover property (@(posedge REF_CLK) disable iff (SYS_RST) HIGH_BANK_OPEN != '0);
  c_ext:     cover property (@(posedge REF_CLK) disable iff (SYS_RST) $rose(EXT_PROG_CLOCK_SEL));
endmodule : oac_top

// ### tb/test_otp_access_config_regs.sv
// testbench: self-checking bench for the fuse access configuration registers
`timescale 1ns/1ps
module test_otp_access_config_regs;
  import oac_pkg::*;
  // ==========================================================
  // stimulus, observation and reference model state
  logic                  REF_CLK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [OAC_ADDR_W-1:0] AVS_ADDRESS = '0;
  logic [31:0]           AVS_WRITEDATA = '0, AVS_READDATA, r;
  logic [3:0]            AVS_BYTEENABLE = 4'hF;
  logic                  AVS_WAITREQUEST, EXT_PROG_CLOCK_SEL, NEG_RAIL_BUFFER_SWITCH;
  logic [1:0]            AVS_RESPONSE, FUSE_OP_SELECT, rsp;
  logic [7:0]            LOW_BANK_OPEN, HIGH_BANK_OPEN, m1, m2, ti;
  logic [31:0]           rnd = 32'h8BDC;
  logic                  g;
  logic [7:0]            tr [16];
  int                    n_mismatch = 0, num_checks = 0, cyc = 0;
  oac_top uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
    .EXT_PROG_CLOCK_SEL(EXT_PROG_CLOCK_SEL), .NEG_RAIL_BUFFER_SWITCH(NEG_RAIL_BUFFER_SWITCH),
    .FUSE_OP_SELECT(FUSE_OP_SELECT), .LOW_BANK_OPEN(LOW_BANK_OPEN), .HIGH_BANK_OPEN(HIGH_BANK_OPEN));
  // 100 MHz clock, and a cycle ceiling so a stuck bus cannot hang the run
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // bank select 1 opens the 0x10 bank; bit 2 covers offsets 0-3, bit 3 offsets 4-7
  function automatic logic open(input logic [7:0] idx);
    return (m2[5] == !idx[5]) && (idx[2] ? m2[3] : m2[2]);
  endfunction : open
  function automatic logic [7:0] expect_rd(input logic [7:0] idx);
    if (idx == OAC_IDX_EVAL_GATE) return {7'h00, g};
    if (idx == OAC_IDX_PROG_CLOCK_CONFIG) return g ? m1 : 8'h00;
    if (idx == OAC_IDX_FUSE_ACCESS_CONTROL) return g ? m2 : 8'h00;
    return (g && open(idx)) ? tr[{idx[5], idx[2:0]}] : 8'h00;
  endfunction : expect_rd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one bus transfer: hold everything until waitrequest is seen low at an edge
  task automatic acc(input logic we, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] be);
    @(posedge REF_CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITE <= we;
    AVS_READ <= !we;
    AVS_WRITEDATA <= wd;
    AVS_BYTEENABLE <= be;
    // only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge REF_CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA;
    rsp = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : acc
  // write through the bus and mirror the effect in the model; gated places drop the write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] up;
    up = lfsr(rnd);
    acc(1'b1, idx, {up[23:0], d}, 4'hF);
    if (idx == OAC_IDX_EVAL_GATE) g = d[0];
    else if (idx == OAC_IDX_PROG_CLOCK_CONFIG && g) m1 = d & OAC_MASK_PROG_CLOCK;
    else if (idx == OAC_IDX_FUSE_ACCESS_CONTROL && g) m2 = d & OAC_MASK_FUSE_ACCESS;
    else if (g && open(idx)) tr[{idx[5], idx[2:0]}] = d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx);
    acc(1'b0, idx, 32'h0, 4'hF);
    check(r, {24'h0, expect_rd(idx)});
  endtask : rd_chk
  // outputs follow the registers one cycle later, so let two edges pass
  task automatic chk_outs();
    logic [7:0] lo, hi;
    repeat (2) @(posedge REF_CLK);
    for (int i = 0; i < 8; i++) begin
      lo[i] = g && open(OAC_IDX_LOW_A_FIRST + 8'(i));
      hi[i] = g && open(OAC_IDX_LOW_B_FIRST + 8'(i));
    end
    check(EXT_PROG_CLOCK_SEL, m1[3]);
    check(NEG_RAIL_BUFFER_SWITCH, m2[4]);
    check(FUSE_OP_SELECT, m2[1:0]);
    check(LOW_BANK_OPEN, lo);
    check(HIGH_BANK_OPEN, hi);
  endtask : chk_outs
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // main sequence
  initial begin
    g = 1'b0;
    m1 = 8'h00;
    m2 = 8'h00;
    foreach (tr[i]) tr[i] = 8'h00;
    repeat (20) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    chk_outs();
    // gate closed: fuse control reads zero and ignores writes; a test register write is sent but not read back
    wr(OAC_IDX_FUSE_ACCESS_CONTROL, 8'h3F);
    wr(8'h10, 8'hA5);
    rd_chk(OAC_IDX_FUSE_ACCESS_CONTROL);
    wr(OAC_IDX_EVAL_GATE, 8'h01);
    rd_chk(OAC_IDX_EVAL_GATE);
    rd_chk(OAC_IDX_FUSE_ACCESS_CONTROL);
    // clock source external then back to internal, the normal setting
    wr(OAC_IDX_PROG_CLOCK_CONFIG, 8'hFF);
    chk_outs();
    rd_chk(OAC_IDX_PROG_CLOCK_CONFIG);
    wr(OAC_IDX_PROG_CLOCK_CONFIG, 8'h00);
    chk_outs();
    // every operation, bank and window combination, with test register traffic in each
    for (int k = 0; k < 64; k++) begin
      rnd = lfsr(rnd);
      wr(OAC_IDX_FUSE_ACCESS_CONTROL, {rnd[7:6], 6'(k)});
      chk_outs();
      rd_chk(OAC_IDX_FUSE_ACCESS_CONTROL);
      ti = {2'b00, rnd[8], 2'b10, rnd[11:9]};
      wr(ti, rnd[23:16]);
      rd_chk(ti);
      rd_chk({2'b00, rnd[12], 2'b10, rnd[15:13]});
    end
    // lane 0 off: the write must not land
    acc(1'b1, OAC_IDX_FUSE_ACCESS_CONTROL, 32'h0000_0015, 4'hE);
    rd_chk(OAC_IDX_FUSE_ACCESS_CONTROL);
    check(rsp, 2'b00);
    // unmapped place answers with an error code and zero data
    acc(1'b0, 8'h20, 32'h0, 4'hF);
    check(r, 32'h0);
    check(rsp, 2'b11);
    // gate closed again: everything behind it hidden
    wr(OAC_IDX_EVAL_GATE, 8'h00);
    rd_chk(OAC_IDX_FUSE_ACCESS_CONTROL);
    rd_chk(ti);
    // second reset mid-run returns everything to zero
    wr(OAC_IDX_EVAL_GATE, 8'h01);
    wr(OAC_IDX_FUSE_ACCESS_CONTROL, 8'h3F);
    chk_outs();
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    g = 1'b0;
    m1 = 8'h00;
    m2 = 8'h00;
    foreach (tr[i]) tr[i] = 8'h00;
    chk_outs();
    rd_chk(OAC_IDX_EVAL_GATE);
    print_verdict();
  end
endmodule : test_otp_access_config_regs
